// ### common/gthc_pkg.sv
// What this block does
// - Result high when input exceeds threshold plus delta.
// - Result low when input at/below threshold minus delta.
// - Inside the band the result holds.
// - Input is signed 16-bit, compared signed.
// - Active on one or always-enabled; else inactive.
// - Inactive: no compare, output frozen.
// - Inputs keep sampling; re-enable uses latest input.
// - Enable may come from several digital sources.
// - Operational input selectable as first block result.
// - Routed channel driven only by the block.
// - Fieldbus bit stays writable and usable as input.
package gthc_pkg;

  // Word offsets of the register map, byte addresses.
  localparam logic [4:0] CTRL_OFF   = 5'h00;
  localparam logic [4:0] THRESH_OFF = 5'h04;
  localparam logic [4:0] DELTA_OFF  = 5'h08;
  localparam logic [4:0] FBUS_OFF   = 5'h0C;
  localparam logic [4:0] STATUS_OFF = 5'h10;

  // Control register field positions.
  localparam int CTRL_ENSRC_LSB = 0;
  localparam int CTRL_ENSRC_W   = 3;
  localparam int CTRL_OPSRC_BIT = 4;
  localparam int CTRL_ROUTE_BIT = 5;

  // Status register field positions.
  localparam int STAT_RESULT_BIT = 0;
  localparam int STAT_ACTIVE_BIT = 1;
  localparam int STAT_OP_LSB     = 16;

  // Reset values.
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [15:0] DELTA_RST  = 16'h0000;

  // Operational word width as documented.
  localparam int OP_W = 16;

  // Sources that can enable the compare.
  typedef enum logic [2:0] {
    GTHC_EN_OFF,
    GTHC_EN_ON,
    GTHC_EN_ISLAND_IN,
    GTHC_EN_ISLAND_OUT,
    GTHC_EN_VMOD,
    GTHC_EN_FBUS
  } gthc_en_src_t;

endpackage

// ### hw/gthc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for levels arriving from pins.
module gthc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // First stage; only the second stage reads it.
  logic [W-1:0] meta;

  // Width below one makes no sense.
  if (W < 1) begin : g_bad_w
    $error("gthc_sync: W must be at least 1.");
  end

  // Both stages clear on reset so the output starts low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

// ### hw/gthc_hyst.sv
`timescale 1ns/1ps
// Signed greater-than compare with symmetric hysteresis.
module gthc_hyst #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         active_i,
  input  wire logic [W-1:0] op_i,
  input  wire logic [W-1:0] thresh_i,
  input  wire logic [W-1:0] delta_i,
  output logic              result_o
);

  if (W < 2 || W > 30) begin : g_bad_w
    $error("gthc_hyst: W must lie in 2..30.");
  end

  // Two spare bits keep sums of extreme presets from wrapping.
  logic signed [W+1:0] op_x;
  logic signed [W+1:0] hi_x;
  logic signed [W+1:0] lo_x;
  logic                above;
  logic                at_or_below;
  logic                next_result;

  assign op_x = (W+2)'($signed(op_i));
  assign hi_x = (W+2)'($signed(thresh_i)) + (W+2)'($signed(delta_i));
  assign lo_x = (W+2)'($signed(thresh_i)) - (W+2)'($signed(delta_i));
  assign above       = op_x > hi_x;
  assign at_or_below = op_x <= lo_x;
  // Above wins if a negative delta makes the band inverted.
  assign next_result = !active_i ? result_o :
                       above ? 1'b1 :
                       at_or_below ? 1'b0 :
                       result_o;

  // Hysteresis state is the result flop itself.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      result_o <= 1'b0;
    else
      result_o <= next_result;
  end

endmodule

// ### hw/gthc_top.sv
`timescale 1ns/1ps
// Greater-than reflex compare with a classic Wishbone register port.
module gthc_top #(
  parameter int OP_W = gthc_pkg::OP_W
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // Classic Wishbone slave.
  input  wire logic [4:0]      adr_i,
  input  wire logic [31:0]     dat_i,
  output logic      [31:0]     dat_o,
  input  wire logic            we_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  output logic                 ack_o,
  // Digital enable candidates from pins.
  input  wire logic            island_din_i,
  input  wire logic            island_dout_i,
  input  wire logic            vmod_dout_i,
  // Operational word sources, same clock domain.
  input  wire logic [OP_W-1:0] op_word_i,
  input  wire logic            first_result_i,
  // Block result and the action channel it may drive.
  output logic                 result_o,
  output logic                 channel_o
);

  if (OP_W != 16) begin : g_bad_w
    $error("gthc_top: the operational word must be 16 bits.");
  end

  // Register storage.
  logic [31:0]     ctrl;          // Source selects and routing.
  logic [15:0]     thresh;        // Threshold preset.
  logic [15:0]     delta;         // Hysteresis preset.
  logic            fbus_bit;      // Fieldbus master data bit.
  logic [OP_W-1:0] op_q;          // Latest operational word.

  // Bus decode.
  logic        req;               // A request stands, not yet answered.
  logic        wr_stb;            // Write takes effect at this edge.
  logic        hit_ctrl;
  logic        hit_thresh;
  logic        hit_delta;
  logic        hit_fbus;
  logic        hit_status;
  logic [31:0] rd_mux;            // Read value before registering.
  logic [31:0] status_word;

  // Compare datapath.
  logic            isl_in_s;      // Synchronised island input.
  logic            isl_out_s;     // Synchronised island output.
  logic            vmod_s;        // Synchronised virtual module bit.
  logic [2:0]      en_sel;
  logic            active;
  logic [OP_W-1:0] op_pick;
  logic            cmp_result;

  // Merge write data into a register under the byte lanes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  lanes);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (lanes[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    end
    return r;
  endfunction

  // Enable candidates from pins cross into this clock first.
  gthc_sync #(.W(3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({vmod_dout_i, island_dout_i, island_din_i}),
    .q_o   ({vmod_s, isl_out_s, isl_in_s})
  );

  // A request is taken once; ack marks the edge it completes.
  assign req        = cyc_i && stb_i && !ack_o;
  assign wr_stb     = cyc_i && stb_i && we_i && ack_o;
  assign hit_ctrl   = adr_i == gthc_pkg::CTRL_OFF;
  assign hit_thresh = adr_i == gthc_pkg::THRESH_OFF;
  assign hit_delta  = adr_i == gthc_pkg::DELTA_OFF;
  assign hit_fbus   = adr_i == gthc_pkg::FBUS_OFF;
  assign hit_status = adr_i == gthc_pkg::STATUS_OFF;

  // Status shows the block's own state and the sampled word.
  assign status_word = {op_q, 14'h0000, active, result_o};

  // Unmapped offsets read as zero and still get an ack.
  assign rd_mux = hit_ctrl   ? ctrl :
                  hit_thresh ? {16'h0000, thresh} :
                  hit_delta  ? {16'h0000, delta} :
                  hit_fbus   ? {31'h0, fbus_bit} :
                  hit_status ? status_word :
                  32'h0000_0000;

  // Ack rises one cycle after the request and drops the next.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= req ? rd_mux : dat_o;
    end
  end

  // Control and presets are written on the acknowledged edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl   <= gthc_pkg::CTRL_RST;
      thresh <= gthc_pkg::THRESH_RST;
      delta  <= gthc_pkg::DELTA_RST;
    end
    else if (wr_stb)
    begin
      if (hit_ctrl)
        ctrl <= merge(ctrl, dat_i, sel_i);
      // Presets keep only the low half; upper lanes are dropped.
      if (hit_thresh)
        thresh <= 16'(merge({16'h0000, thresh}, dat_i, sel_i));
      if (hit_delta)
        delta <= 16'(merge({16'h0000, delta}, dat_i, sel_i));
    end
  end

  // The fieldbus bit is always writable, routed or not.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fbus_bit <= 1'b0;
    else if (wr_stb && hit_fbus && sel_i[0])
      fbus_bit <= dat_i[0];
  end

  // Enable source select; unknown codes count as disabled.
  assign en_sel = ctrl[gthc_pkg::CTRL_ENSRC_LSB +: gthc_pkg::CTRL_ENSRC_W];
  always_comb
  begin
    case (gthc_pkg::gthc_en_src_t'(en_sel))
      gthc_pkg::GTHC_EN_ON:         active = 1'b1;
      gthc_pkg::GTHC_EN_ISLAND_IN:  active = isl_in_s;
      gthc_pkg::GTHC_EN_ISLAND_OUT: active = isl_out_s;
      gthc_pkg::GTHC_EN_VMOD:       active = vmod_s;
      gthc_pkg::GTHC_EN_FBUS:       active = fbus_bit;
      default:                      active = 1'b0;
    endcase
  end

  // Nested mode widens the first block's bit into a word.
  assign op_pick = ctrl[gthc_pkg::CTRL_OPSRC_BIT] ?
                   {{(OP_W-1){1'b0}}, first_result_i} :
                   op_word_i;

  // The word is sampled every cycle, enabled or not, so a
  // re-enable acts on the freshest value.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      op_q <= '0;
    else
      op_q <= op_pick;
  end

  // Compare core holds the hysteresis state.
  gthc_hyst #(.W(OP_W)) u_hyst (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .active_i (active),
    .op_i     (op_q),
    .thresh_i (thresh),
    .delta_i  (delta),
    .result_o (cmp_result)
  );

  assign result_o = cmp_result;

  // A routed channel follows the block only; else the fieldbus.
  assign channel_o = ctrl[gthc_pkg::CTRL_ROUTE_BIT] ?
                     cmp_result : fbus_bit;

  // Helper views for the checks below.
  logic signed [17:0] op_x;
  logic signed [17:0] hi_x;
  logic signed [17:0] lo_x;
  assign op_x = 18'($signed(op_q));
  assign hi_x = 18'($signed(thresh)) + 18'($signed(delta));
  assign lo_x = 18'($signed(thresh)) - 18'($signed(delta));

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_cmp_above_high: assert property (
    active && op_x > hi_x |=> result_o)
    else $error("Result not high above upper bound.");

  a_cmp_below_low: assert property (
    active && op_x <= lo_x && !(op_x > hi_x) |=> !result_o)
    else $error("Result not low at or below lower bound.");

  a_band_holds: assert property (
    active && op_x > lo_x && op_x <= hi_x |=> $stable(result_o))
    else $error("Result moved inside the band.");

  a_signed_cmp: assert property (
    active && op_q[15] && !thresh[15] && delta == 16'h0000
    |=> !result_o)
    else $error("Negative input compared as unsigned.");

  a_off_frozen: assert property (
    !active |=> $stable(result_o))
    else $error("Output changed while inactive.");

  a_always_on: assert property (
    en_sel == 3'h1 |-> active)
    else $error("Always-enabled source not active.");

  a_sample_live: assert property (
    !active ##1 !active |-> op_q == $past(op_pick))
    else $error("Input sampling stopped while inactive.");

  a_route_only: assert property (
    ctrl[gthc_pkg::CTRL_ROUTE_BIT] |-> channel_o == result_o)
    else $error("Routed channel not driven by the block.");

  a_fbus_write: assert property (
    wr_stb && hit_fbus && sel_i[0] |=> fbus_bit == $past(dat_i[0]))
    else $error("Fieldbus bit write lost.");

  a_nested_src: assert property (
    ctrl[gthc_pkg::CTRL_OPSRC_BIT] |=>
    op_q == {15'h0, $past(first_result_i)})
    else $error("Nested input not taken from first block.");

  a_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("Ack held longer than one cycle.");

  a_reset_low: assert property (
    @(posedge clk_i) $past(rst_i) |-> !result_o)
    else $error("Output not low after reset.");

  c_rise: cover property (active && !result_o ##1 result_o);
  c_fall: cover property (active && result_o ##1 !result_o);
  c_freeze: cover property (!active ##1 !active [*3] ##1 active);
  c_routed: cover property (ctrl[gthc_pkg::CTRL_ROUTE_BIT] && result_o);

endmodule

// ### bench/gthc_field_model.sv
`timescale 1ns/1ps
// Far side: island pins, virtual module bit, nested result and the word.
module gthc_field_model (
  input  wire logic        clk_i,
  output logic      [15:0] op_o,
  output logic             din_o,
  output logic             dout_o,
  output logic             vmod_o,
  output logic             first_o
);
  // A quiet field at start, so no stray level reaches the compare.
  initial
  begin
    {op_o, din_o, dout_o, vmod_o, first_o} = '0;
  end

  // New field values land just after an edge.
  // The first block's result only feeds this block, no channel.
  task automatic put(input logic [15:0] op, input logic [3:0] b);
    @(posedge clk_i);
    op_o <= op;
    {din_o, dout_o, vmod_o, first_o} <= b;
  endtask
endmodule

// ### bench/gthc_top_tb_top.sv
`timescale 1ns/1ps
// Register calls and field stimulus, each followed by expected values.
module gthc_top_tb_top;
  localparam logic [4:0] A_C = gthc_pkg::CTRL_OFF;
  localparam logic [4:0] A_T = gthc_pkg::THRESH_OFF;
  localparam logic [4:0] A_D = gthc_pkg::DELTA_OFF;
  localparam logic [4:0] A_F = gthc_pkg::FBUS_OFF;
  localparam logic [4:0] A_S = gthc_pkg::STATUS_OFF;
  logic        clk_i = 1'b0;  // 125 MHz.
  logic        rst_i = 1'b1;  // Held for 8 cycles.
  logic [4:0]  adr_i = 5'h00;
  logic [31:0] dat_i = 32'h0;
  logic        we_i  = 1'b0;
  logic [3:0]  sel_i = 4'h0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        result_o;
  logic        channel_o;
  logic [15:0] op;
  logic        din;
  logic        dout;
  logic        vmod;
  logic        first;
  logic [31:0] rd;
  logic [3:0]  lanes = 4'hF;  // Byte lanes used by the next calls.
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  // Pin mask per enable code; codes 2 to 4 raise only their own pin, codes 0, 6 and 7 raise all three pins.
  logic [3:0]  pin [8] = '{4'hE, 4'h0, 4'h8, 4'h4, 4'h2, 4'h0, 4'hE, 4'hE};

  always #4 clk_i = ~clk_i;

  gthc_field_model field (.clk_i(clk_i), .op_o(op), .din_o(din),
    .dout_o(dout), .vmod_o(vmod), .first_o(first));

  gthc_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .island_din_i(din), .island_dout_i(dout), .vmod_dout_i(vmod),
    .op_word_i(op), .first_result_i(first), .result_o(result_o),
    .channel_o(channel_o));

  // One classic cycle; the request stands until ack is seen at an edge.
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, lanes};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input logic e);
    chk("result", {31'h0, result_o}, {31'h0, e});
  endtask

  // Five cycles cover the two-cycle compare plus pin synchronisers.
  task automatic drive(input logic [15:0] v, input logic [3:0] b);
    field.put(v, b);
    repeat (5) @(posedge clk_i);
    #1;
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang counts as a mismatch; the sequence needs far fewer cycles.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      finish_test;
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    rchk(1'b0);
    wb(1'b0, A_C, 32'h0);
    chk("ctrl", rd, gthc_pkg::CTRL_RST);
    $display("Test reset done");
    wb(1'b1, A_T, 32'h0000_0640);
    wb(1'b0, A_T, 32'h0);
    chk("thresh", rd, 32'h0000_0640);
    wb(1'b1, A_D, 32'h0000_0020);
    wb(1'b1, A_C, 32'h0000_0001);
    drive(16'h0660, 4'h0);
    rchk(1'b0);
    drive(16'h0661, 4'h0);
    rchk(1'b1);
    drive(16'h0621, 4'h0);
    rchk(1'b1);
    drive(16'h0620, 4'h0);
    rchk(1'b0);
    $display("Test band done");
    // Enable codes: only 1 to 5 may let a high word through.
    for (int s = 0; s < 8; s++)
    begin
      wb(1'b1, A_C, 32'(s));
      wb(1'b1, A_F, {31'h0, s == 0 || s > 4});
      drive(16'h0700, pin[s]);
      rchk(s inside {[1:5]});
      drive(16'h0620, pin[s]);
      rchk(1'b0);
    end
    $display("Test enable done");
    wb(1'b1, A_C, 32'h0000_0001);
    drive(16'h0700, 4'h0);
    wb(1'b0, A_S, 32'h0);
    chk("status", rd, 32'h0700_0003);
    wb(1'b1, A_C, 32'h0);
    drive(16'h0600, 4'h0);
    rchk(1'b1);
    wb(1'b0, A_S, 32'h0);
    chk("status", rd, 32'h0600_0001);
    wb(1'b1, A_C, 32'h0000_0001);
    @(posedge clk_i);
    #1;
    rchk(1'b0);
    drive(16'h0600, 4'h0);
    rchk(1'b0);
    $display("Test freeze done");
    wb(1'b1, A_C, 32'h0000_0021);
    wb(1'b1, A_F, 32'h1);
    drive(16'h0600, 4'h0);
    chk("channel", {31'h0, channel_o}, 32'h0);
    wb(1'b0, A_F, 32'h0);
    chk("fbus", rd, 32'h1);
    drive(16'h0700, 4'h0);
    chk("channel", {31'h0, channel_o}, 32'h1);
    wb(1'b1, A_C, 32'h0000_0001);
    wb(1'b1, A_F, 32'h0);
    drive(16'h0700, 4'h0);
    chk("channel", {31'h0, channel_o}, 32'h0);
    $display("Test route done");
    wb(1'b1, A_T, 32'h0);
    wb(1'b1, A_D, 32'h0);
    wb(1'b1, A_C, 32'h0000_0011);
    drive(16'h7FFF, 4'h0);
    rchk(1'b0);
    drive(16'h8000, 4'h1);
    rchk(1'b1);
    wb(1'b1, A_C, 32'h0000_0001);
    drive(16'h8000, 4'h0);
    rchk(1'b0);
    drive(16'h7FFF, 4'h0);
    rchk(1'b1);
    wb(1'b1, 5'h14, 32'hFFFF_FFFF);
    wb(1'b0, 5'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
    lanes = 4'hE;
    wb(1'b1, A_T, 32'hFFFF_CD34);
    wb(1'b1, A_F, 32'h1);
    lanes = 4'hF;
    wb(1'b0, A_T, 32'h0);
    chk("lanes", rd, 32'h0000_CD00);
    wb(1'b0, A_F, 32'h0);
    chk("fbus", rd, 32'h0);
    $display("Test nested done");
    finish_test;
  end
endmodule
